// ==== hw/csfb_defines.svh ====
// Purpose: Constants of the core status register with bank selection.
// Assumes: One 8-bit register, reached by the core's file-register port.
// Notes:   Offsets, bit positions and reset values are named here.
//
// Operation
// - Any instruction may target the status register like a file register.
// - Status-targeted flag-updating ops load zero/digit/carry from ALU, not data.
// - Writes to watchdog expiry and sleep entered flags are ignored.
// - Clearing status zeroes bank bits, keeps reset flags, sets zero flag.
// - In subtraction carry and digit carry mean no borrow when one.
// - Indirect page bit selects banks 2-3 when one, 0-1 when zero.
// - Direct page bits pick bank 0..3 by their two-bit value.
// - Watchdog expiry flag sets at power-up, kick, sleep; clears on timeout.
// - Subtraction adds the two's complement of the second operand.
// - Rotates load carry with the shifted-out bit of the source.
`ifndef CSFB_DEFINES_SVH
`define CSFB_DEFINES_SVH

`define CSFB_STATUS_OFS    7'h03
`define CSFB_BIT_IPAGE     7
`define CSFB_BIT_DPAGE_HI  6
`define CSFB_BIT_DPAGE_LO  5
`define CSFB_BIT_WDEXP     4
`define CSFB_BIT_SLEEP     3
`define CSFB_BIT_ZERO      2
`define CSFB_BIT_DCARRY    1
`define CSFB_BIT_CARRY     0
`define CSFB_RESET_VAL     8'h18

`endif

// ==== hw/csfb_pkg.sv ====
// Purpose: Types of the core status register block.
// Assumes: Included defines give the numbers.
// Notes:   Operation codes are abstract; the decoder maps instructions.
package csfb_pkg;

    // ALU operations seen by the status block.
    typedef enum logic [3:0]
    {
        CSFB_OP_NONE,
        CSFB_OP_ADD,
        CSFB_OP_SUB,
        CSFB_OP_AND,
        CSFB_OP_IOR,
        CSFB_OP_XOR,
        CSFB_OP_MOVE,
        CSFB_OP_CLEAR,
        CSFB_OP_ROR,
        CSFB_OP_ROL,
        CSFB_OP_SWAP,
        CSFB_OP_PASS
    } csfb_op_e;

    // One executed instruction as presented by the execution unit.
    typedef struct packed
    {
        logic     valid;
        csfb_op_e op;
        logic [7:0] a;
        logic [7:0] b;
        logic       wr_en;
        logic [6:0] wr_addr;
    } csfb_exec_s;

    // Result of the datapath.
    typedef struct packed
    {
        logic [7:0] result;
        logic       zero;
        logic       dcarry;
        logic       carry;
        logic       upd_z;
        logic       upd_c;
    } csfb_alu_s;

endpackage

// ==== hw/csfb_alu.sv ====
// Purpose: Eight-bit ALU that produces the result and arithmetic flags.
// Assumes: Purely combinational; the status block registers the outputs.
// Notes:   Subtract is a + ~b + 1, so carry one means no borrow.
`timescale 1ns/1ps
`include "csfb_defines.svh"
module csfb_alu
    import csfb_pkg::*;
(
    // Operands
    input  wire csfb_op_e   op_i,
    input  wire logic [7:0] a_i,
    input  wire logic [7:0] b_i,
    input  wire logic       carry_in_i,
    // Result
    output csfb_alu_s       alu_o
);

    logic [4:0] lo_sum;
    logic [8:0] full_sum;
    logic [7:0] addend;
    logic       cin;

    always_comb
    begin
        addend = b_i;
        cin    = 1'b0;
        if (op_i == CSFB_OP_SUB)
        begin
            addend = ~b_i;
            cin    = 1'b1;
        end
        lo_sum   = {1'b0, a_i[3:0]} + {1'b0, addend[3:0]} + {4'h0, cin};
        full_sum = {1'b0, a_i} + {1'b0, addend} + {8'h00, cin};
    end

    always_comb
    begin
        alu_o        = '0;
        alu_o.carry  = carry_in_i;
        unique case (op_i)
            CSFB_OP_ADD, CSFB_OP_SUB:
            begin
                alu_o.result = full_sum[7:0];
                alu_o.dcarry = lo_sum[4];
                alu_o.carry  = full_sum[8];
                alu_o.upd_z  = 1'b1;
                alu_o.upd_c  = 1'b1;
            end
            CSFB_OP_AND:
            begin
                alu_o.result = a_i & b_i;
                alu_o.upd_z  = 1'b1;
            end
            CSFB_OP_IOR:
            begin
                alu_o.result = a_i | b_i;
                alu_o.upd_z  = 1'b1;
            end
            CSFB_OP_XOR:
            begin
                alu_o.result = a_i ^ b_i;
                alu_o.upd_z  = 1'b1;
            end
            CSFB_OP_MOVE:
            begin
                alu_o.result = a_i;
                alu_o.upd_z  = 1'b1;
            end
            CSFB_OP_CLEAR:
            begin
                alu_o.result = 8'h00;
                alu_o.upd_z  = 1'b1;
            end
            CSFB_OP_ROR:
            begin
                alu_o.result = {carry_in_i, a_i[7:1]};
                alu_o.carry  = a_i[0];
            end
            CSFB_OP_ROL:
            begin
                alu_o.result = {a_i[6:0], carry_in_i};
                alu_o.carry  = a_i[7];
            end
            CSFB_OP_SWAP: alu_o.result = {a_i[3:0], a_i[7:4]};
            CSFB_OP_PASS: alu_o.result = a_i;
            default:      alu_o.result = a_i;
        endcase
        alu_o.zero = (alu_o.result == 8'h00);
    end

endmodule

// ==== hw/csfb_status.sv ====
// Purpose: Core status register with ALU flags, reset causes and banks.
// Assumes: One instruction per clock; writes take effect at the edge.
// Notes:   Flag updates override a data write to the same status bits.
`timescale 1ns/1ps
`include "csfb_defines.svh"
module csfb_status
    import csfb_pkg::*;
(
    // Clock and reset
    input  wire logic       clock_i,
    input  wire logic       rst_i,
    // Execution unit
    input  wire csfb_exec_s exec_i,
    input  wire logic       dog_kick_i,
    input  wire logic       sleep_i,
    input  wire logic       dog_timeout_i,
    // Results
    output logic [7:0]      result_o,
    output logic [7:0]      status_o,
    output logic [1:0]      direct_bank_o,
    output logic [8:0]      indirect_base_o
);

    csfb_alu_s  alu;
    logic [7:0] st_r;
    logic [7:0] st_nxt;
    logic       hit;

    csfb_alu u_alu
    (
        .op_i       (exec_i.op),
        .a_i        (exec_i.a),
        .b_i        (exec_i.b),
        .carry_in_i (st_r[`CSFB_BIT_CARRY]),
        .alu_o      (alu)
    );

    // ==========================================================
    // Next status value
    always_comb
    begin
        st_nxt = st_r;
        hit    = exec_i.valid && exec_i.wr_en &&
                 (exec_i.wr_addr == `CSFB_STATUS_OFS);
        if (hit)
        begin
            // Writable bits take the result like any file register.
            st_nxt[7:5] = alu.result[7:5];
            st_nxt[2:0] = alu.result[2:0];
        end
        if (exec_i.valid && alu.upd_z)
            st_nxt[`CSFB_BIT_ZERO] = alu.zero;
        else if (hit && (exec_i.op == CSFB_OP_ROR ||
                         exec_i.op == CSFB_OP_ROL))
        begin
            // A rotate owns the carry, so zero and digit carry are shielded.
            st_nxt[`CSFB_BIT_ZERO]   = st_r[`CSFB_BIT_ZERO];
            st_nxt[`CSFB_BIT_DCARRY] = st_r[`CSFB_BIT_DCARRY];
        end
        if (exec_i.valid && alu.upd_c)
        begin
            st_nxt[`CSFB_BIT_DCARRY] = alu.dcarry;
            st_nxt[`CSFB_BIT_CARRY]  = alu.carry;
        end
        else if (hit && alu.upd_z)
        begin
            st_nxt[1:0] = st_r[1:0];
        end
        if (exec_i.valid && (exec_i.op == CSFB_OP_ROR ||
                             exec_i.op == CSFB_OP_ROL))
            st_nxt[`CSFB_BIT_CARRY] = alu.carry;
        // Reset-cause bits ignore data writes; only events move them.
        st_nxt[`CSFB_BIT_WDEXP] = st_r[`CSFB_BIT_WDEXP];
        st_nxt[`CSFB_BIT_SLEEP] = st_r[`CSFB_BIT_SLEEP];
        if (dog_kick_i)
        begin
            st_nxt[`CSFB_BIT_WDEXP] = 1'b1;
            st_nxt[`CSFB_BIT_SLEEP] = 1'b1;
        end
        else if (sleep_i)
        begin
            st_nxt[`CSFB_BIT_WDEXP] = 1'b1;
            st_nxt[`CSFB_BIT_SLEEP] = 1'b0;
        end
        // A time-out is the cause to remember, so it wins over a kick.
        if (dog_timeout_i)
            st_nxt[`CSFB_BIT_WDEXP] = 1'b0;
    end

    // ==========================================================
    // Status register
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
            st_r <= `CSFB_RESET_VAL;
        else
            st_r <= st_nxt;
    end

    // ==========================================================
    // Registered outputs
    always_ff @(posedge clock_i)
    begin
        if (rst_i)
        begin
            result_o        <= 8'h00;
            status_o        <= `CSFB_RESET_VAL;
            direct_bank_o   <= 2'b00;
            indirect_base_o <= 9'h000;
        end
        else
        begin
            result_o        <= alu.result;
            status_o        <= st_nxt;
            direct_bank_o   <= st_nxt[6:5];
            indirect_base_o <= {st_nxt[`CSFB_BIT_IPAGE], 8'h00};
        end
    end

    // ==========================================================
    // Checks
    // Every check runs on the core clock and rests while reset is held.
    default clocking chk_cb @(posedge clock_i);
    endclocking
    default disable iff (rst_i);

    // Any reset-cause event moves the reset-cause bits on purpose.
    logic       any_evt;
    // Operand arithmetic done apart from the ALU, so a broken adder shows.
    logic [4:0] chk_lo;
    logic [8:0] chk_sum;
    logic [7:0] chk_diff;

    assign any_evt  = dog_kick_i | sleep_i | dog_timeout_i;
    assign chk_lo   = {1'b0, exec_i.a[3:0]} + {1'b0, exec_i.b[3:0]};
    assign chk_sum  = {1'b0, exec_i.a} + {1'b0, exec_i.b};
    assign chk_diff = exec_i.a - exec_i.b;

    sequence kick_s;
        dog_kick_i && !dog_timeout_i;
    endsequence

    sequence sleep_s;
        sleep_i && !dog_kick_i && !dog_timeout_i;
    endsequence

    sequence quiet_write_s;
        hit && !any_evt;
    endsequence

    sequence clear_write_s;
        hit && exec_i.op == CSFB_OP_CLEAR && !any_evt;
    endsequence

    sequence sub_issue_s;
        exec_i.valid && exec_i.op == CSFB_OP_SUB;
    endsequence

    sequence add_issue_s;
        exec_i.valid && exec_i.op == CSFB_OP_ADD;
    endsequence

    sequence rotate_write_s;
        hit && (exec_i.op == CSFB_OP_ROR || exec_i.op == CSFB_OP_ROL);
    endsequence

    sequence pass_write_s;
        hit && exec_i.op == CSFB_OP_PASS;
    endsequence

    reg_ro_a: assert property (quiet_write_s |=>
        st_r[4:3] == $past(st_r[4:3]))
        else $error("reset-cause bits changed by a write");

    kick_set_a: assert property (kick_s |=>
        st_r[4:3] == 2'b11)
        else $error("kick did not set both reset-cause bits");

    sleep_bits_a: assert property (sleep_s |=>
        st_r[4:3] == 2'b10)
        else $error("sleep did not set expiry and clear sleep flag");

    timeout_a: assert property (dog_timeout_i |=>
        !st_r[4])
        else $error("time-out did not clear expiry flag");

    clear_st_a: assert property (clear_write_s |=>
        st_r == {3'b000, $past(st_r[4:3]), 1'b1, $past(st_r[1:0])})
        else $error("clear of status gave wrong value");

    sub_carry_a: assert property (sub_issue_s |=>
        st_r[0] == ($past(exec_i.a) >= $past(exec_i.b)))
        else $error("borrow polarity wrong");

    sub_flags_a: assert property (sub_issue_s |=>
        st_r[1] == ($past(exec_i.a[3:0]) >= $past(exec_i.b[3:0])) &&
        result_o == $past(chk_diff))
        else $error("subtract result or digit borrow wrong");

    add_flags_a: assert property (add_issue_s |=>
        st_r[1:0] == {$past(chk_lo[4]), $past(chk_sum[8])} &&
        result_o == $past(chk_sum[7:0]))
        else $error("add result or carries wrong");

    zero_flag_a: assert property (exec_i.valid && alu.upd_z |=>
        st_r[2] == (result_o == 8'h00))
        else $error("zero flag does not match result");

    rot_carry_a: assert property (
        exec_i.valid && exec_i.op == CSFB_OP_ROR |=>
        st_r[0] == $past(exec_i.a[0]))
        else $error("rotate right carry wrong");

    rol_carry_a: assert property (
        exec_i.valid && exec_i.op == CSFB_OP_ROL |=>
        st_r[0] == $past(exec_i.a[7]))
        else $error("rotate left carry wrong");

    rot_keep_a: assert property (rotate_write_s |=>
        st_r[2:1] == $past(st_r[2:1]))
        else $error("rotate into status changed zero or digit carry");

    pass_write_a: assert property (pass_write_s |=>
        st_r[7:5] == $past(exec_i.a[7:5]) &&
        st_r[2:0] == $past(exec_i.a[2:0]))
        else $error("plain store to status did not land");

    bank_out_a: assert property (
        direct_bank_o == st_r[6:5] && indirect_base_o[8] == st_r[7])
        else $error("bank outputs disagree with status");

    page_base_a: assert property (
        indirect_base_o == {st_r[`CSFB_BIT_IPAGE], 8'h00})
        else $error("indirect base does not follow page bit");

endmodule

// ==== testbench/csfb_exec_model.sv ====
// Purpose: Model of the execution unit that feeds the status block.
// Assumes: The bench calls issue just after a falling clock edge.
// Notes:   Idle operands are inverted so stale values never look valid.
`timescale 1ns/1ps
`include "csfb_defines.svh"
module csfb_exec_model
    import csfb_pkg::*;
(
    // Instruction and events
    output csfb_exec_s exec_o,
    output logic       kick_o,
    output logic       sleep_o,
    output logic       tmo_o
);
    initial
    begin
        exec_o  = '0;
        kick_o  = 1'h0;
        sleep_o = 1'h0;
        tmo_o   = 1'h0;
    end

    // ==========================================================
    // Issue one instruction, or idle with events only
    task automatic issue(input csfb_op_e   op,
                         input logic [7:0] a,
                         input logic [7:0] b,
                         input logic       st,
                         input logic [2:0] ev);
        logic v;
        v                = (op != CSFB_OP_NONE);
        exec_o.valid     = v;
        exec_o.op        = op;
        exec_o.a         = v ? a : ~exec_o.a;
        exec_o.b         = v ? b : ~exec_o.b;
        exec_o.wr_en     = v;
        // Ops with st set write the status register; the rest write address 7'h04.
        exec_o.wr_addr   = st ? `CSFB_STATUS_OFS : 7'h04;
        {kick_o, sleep_o, tmo_o} = ev;
    endtask
endmodule

// ==== testbench/tb_top.sv ====
// Purpose: Self-checking bench of the core status register block.
// Assumes: One instruction per cycle; outputs settle by the next fall.
// Notes:   Rows run back to back, so each row sees the last one's flags.
`timescale 1ns/1ps
`include "csfb_defines.svh"
module tb_top
    import csfb_pkg::*;
;
    typedef struct packed
    {
        csfb_op_e   op;
        logic [7:0] a;
        logic [7:0] b;
        logic       st;
        logic [2:0] ev;
        logic [7:0] r;
        logic [7:0] s;
    } csfb_row_s;

    logic       clock_i     = 1'h0;
    logic       rst_i       = 1'h1;
    csfb_exec_s exec_w;
    logic       kick_w;
    logic       sleep_w;
    logic       tmo_w;
    logic [7:0] result_w;
    logic [7:0] status_w;
    logic [1:0] dbank_w;
    logic [8:0] ibase_w;
    int         miscompares = 0;
    int         cmp_count   = 0;

    // Event column is {kick, sleep, time-out}.
    csfb_row_s rows [24] = '{
        '{CSFB_OP_SUB,  8'h05, 8'h03, 1'h0, 3'h0, 8'h02, 8'h1B},
        '{CSFB_OP_SUB,  8'h03, 8'h05, 1'h0, 3'h0, 8'hFE, 8'h18},
        '{CSFB_OP_ADD,  8'h0F, 8'h01, 1'h0, 3'h0, 8'h10, 8'h1A},
        '{CSFB_OP_ADD,  8'hFF, 8'h01, 1'h0, 3'h0, 8'h00, 8'h1F},
        '{CSFB_OP_AND,  8'hF0, 8'h0F, 1'h0, 3'h0, 8'h00, 8'h1F},
        '{CSFB_OP_IOR,  8'h30, 8'h00, 1'h0, 3'h0, 8'h30, 8'h1B},
        '{CSFB_OP_XOR,  8'h55, 8'h55, 1'h0, 3'h0, 8'h00, 8'h1F},
        '{CSFB_OP_ROR,  8'h02, 8'h02, 1'h0, 3'h0, 8'h81, 8'h1E},
        '{CSFB_OP_ROL,  8'h81, 8'h81, 1'h0, 3'h0, 8'h02, 8'h1F},
        '{CSFB_OP_MOVE, 8'h05, 8'h05, 1'h0, 3'h0, 8'h05, 8'h1B},
        '{CSFB_OP_SUB,  8'h10, 8'h01, 1'h0, 3'h0, 8'h0F, 8'h19},
        '{CSFB_OP_PASS, 8'h00, 8'h00, 1'h1, 3'h0, 8'h00, 8'h18},
        '{CSFB_OP_PASS, 8'hE7, 8'hE7, 1'h1, 3'h0, 8'hE7, 8'hFF},
        '{CSFB_OP_PASS, 8'h40, 8'h40, 1'h1, 3'h0, 8'h40, 8'h58},
        '{CSFB_OP_PASS, 8'hA0, 8'hA0, 1'h1, 3'h0, 8'hA0, 8'hB8},
        '{CSFB_OP_ADD,  8'hFF, 8'h01, 1'h1, 3'h0, 8'h00, 8'h1F},
        '{CSFB_OP_PASS, 8'hE3, 8'hE3, 1'h1, 3'h0, 8'hE3, 8'hFB},
        '{CSFB_OP_CLEAR, 8'h00, 8'h00, 1'h1, 3'h0, 8'h00, 8'h1F},
        '{CSFB_OP_NONE, 8'h00, 8'h00, 1'h0, 3'h1, 8'h00, 8'h0F},
        '{CSFB_OP_NONE, 8'h00, 8'h00, 1'h0, 3'h2, 8'h00, 8'h17},
        '{CSFB_OP_NONE, 8'h00, 8'h00, 1'h0, 3'h4, 8'h00, 8'h1F},
        '{CSFB_OP_NONE, 8'h00, 8'h00, 1'h0, 3'h5, 8'h00, 8'h0F},
        '{CSFB_OP_NONE, 8'h00, 8'h00, 1'h0, 3'h4, 8'h00, 8'h1F},
        '{CSFB_OP_ROR,  8'h1B, 8'h1B, 1'h1, 3'h0, 8'h8D, 8'h9F}
    };

    always #5 clock_i = ~clock_i;

    csfb_exec_model u_exec
    (
        .exec_o  (exec_w),
        .kick_o  (kick_w),
        .sleep_o (sleep_w),
        .tmo_o   (tmo_w)
    );

    csfb_status dut
    (
        .clock_i         (clock_i),
        .rst_i           (rst_i),
        .exec_i          (exec_w),
        .dog_kick_i      (kick_w),
        .sleep_i         (sleep_w),
        .dog_timeout_i   (tmo_w),
        .result_o        (result_w),
        .status_o        (status_w),
        .direct_bank_o   (dbank_w),
        .indirect_base_o (ibase_w)
    );

    // ==========================================================
    // Reporting
    task automatic chk(input string n, input logic [8:0] e,
                       input logic [8:0] g);
        cmp_count++;
        if (g !== e)
        begin
            $display("unexpected %s expected %h seen %h", n, e, g);
            miscompares++;
        end
    endtask

    task automatic end_of_test();
        if (miscompares == 0 && cmp_count > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic check_out(input logic [7:0] s, input logic [7:0] r,
                             input logic v);
        chk("status", {1'h0, s}, {1'h0, status_w});
        if (v)
            chk("result", {1'h0, r}, {1'h0, result_w});
        chk("direct_bank", {7'h00, s[6:5]}, {7'h00, dbank_w});
        chk("indirect_base", {s[7], 8'h00}, ibase_w);
    endtask

    // Held for 16 cycles, so a write issued with it lands only after release.
    task automatic do_reset();
        rst_i = 1'h1;
        repeat (16) @(negedge clock_i);
        rst_i = 1'h0;
        check_out(`CSFB_RESET_VAL, 8'h00, 1'h1);
    endtask

    // ==========================================================
    // Main sequence
    initial
    begin
        do_reset();
        foreach (rows[i])
        begin
            u_exec.issue(rows[i].op, rows[i].a, rows[i].b, rows[i].st,
                         rows[i].ev);
            @(negedge clock_i);
            check_out(rows[i].s, rows[i].r, rows[i].op != CSFB_OP_NONE);
        end
        // Kick meets sleep and a status store; then sleep meets time-out.
        u_exec.issue(CSFB_OP_PASS, 8'h00, 8'h00, 1'h1, 3'h6);
        @(negedge clock_i);
        check_out(8'h18, 8'h00, 1'h1);
        u_exec.issue(CSFB_OP_NONE, 8'h00, 8'h00, 1'h0, 3'h3);
        @(negedge clock_i);
        check_out(8'h00, 8'h00, 1'h0);
        u_exec.issue(CSFB_OP_PASS, 8'hE7, 8'hE7, 1'h1, 3'h0);
        do_reset();
        // The store still presented lands in the first cycle after release.
        @(negedge clock_i);
        check_out(8'hFF, 8'hE7, 1'h1);
        end_of_test();
    end
endmodule
